// file: ipdc_pkg.sv
package ipdc_pkg;
  // Register map and field layout of the power control register
  localparam logic [7:0] IPDC_POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] IPDC_POWER_CONTROL_RESET = 8'h00;
  localparam int IPDC_BIT_IDLE = 0;
  localparam int IPDC_BIT_PDOWN = 1;
  localparam int IPDC_BIT_GF0 = 2;
  localparam int IPDC_BIT_GF1 = 3;
  localparam int IPDC_BIT_POF = 4;
  localparam int IPDC_BIT_RSVD = 5;
  localparam int IPDC_BIT_SMOD0 = 6;
  localparam int IPDC_BIT_SMOD = 7;
  localparam logic [7:0] IPDC_RW_MASK = 8'hDF;
  // Number of keypad pins
  localparam int IPDC_KEYS = 8;
  // Wake source indices inside the wake vector
  localparam int IPDC_SRC_EXT0 = 0;
  localparam int IPDC_SRC_EXT1 = 1;
  localparam int IPDC_SRC_BOD = 2;
  localparam int IPDC_SRC_WDT = 3;
  localparam int IPDC_SRC_KEY = 4;
  localparam int IPDC_NSRC = 5;

  // Controller states
  typedef enum logic [1:0] {
    IPDC_RUN,
    IPDC_IDLE,
    IPDC_PDOWN,
    IPDC_WAKE
  } ipdc_state_t;

  // Register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ipdc_bus_t;

  // Clock gate and hold outputs toward the core
  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic pc_hold;
    logic port_hold;
    logic flash_stop;
    logic wdt_clear;
  } ipdc_ctl_t;
endpackage : ipdc_pkg

// file: ipdc_ctrl.sv
`timescale 1ns/1ps
module ipdc_ctrl
  import ipdc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Reset sources: hardware, software and power-on, already synchronous
  input wire logic HW_RESET,
  input wire logic SW_RESET,
  input wire logic POR_EVENT,
  // Interrupt enables from the interrupt controller
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  input wire logic [IPDC_NSRC-1:0] SRC_ENABLE,
  // Interrupt requests while clocks run
  input wire logic [IPDC_NSRC-1:0] IRQ_PENDING,
  // Asynchronous wake pins and the brownout wake enable
  input wire logic EXT0_PIN_N,
  input wire logic EXT1_PIN_N,
  input wire logic BROWNOUT_DETECTOR,
  input wire logic BOD_ENABLE,
  input wire logic WATCHDOG_IRQ,
  input wire logic [IPDC_KEYS-1:0] KEY_PIN,
  // Core handshake: one pulse when the core has vectored to the wake interrupt
  input wire logic VECTOR_ACK,
  // Outputs toward core and peripherals
  output logic CPU_CLK_EN,
  output logic PER_CLK_EN,
  output logic PC_HOLD,
  output logic PORT_HOLD,
  output logic FLASH_STOP,
  output logic WATCHDOG_COUNTER_CLEAR,
  output logic WAKE_IRQ,
  output logic [IPDC_NSRC-1:0] WAKE_SOURCE,
  output logic PROGRAM_RESTART,
  output logic [1:0] MODE
);

  ipdc_bus_t bus; // Bundled register request
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Power control register and state
  logic [7:0] power_control_reg_ff;
  logic [7:0] nxt_power_control_reg;
  ipdc_state_t state_ff;
  ipdc_state_t nxt_state;
  logic [7:0] rdata_ff;
  logic [IPDC_KEYS-1:0] key_entry_ff; // Keypad level latched at entry
  logic [IPDC_NSRC-1:0] src_ff; // Waking source
  logic [IPDC_NSRC-1:0] nxt_src;
  ipdc_ctl_t ctl_ff;
  ipdc_ctl_t nxt_ctl;
  logic restart_ff; // Program restart pulse after a pin or power-on reset
  // Vector request toward the core, registered so the pin comes from a flop
  logic wake_irq_ff;
  // Next vector request: only in the wake state and only with the CPU clock on
  logic nxt_wake_irq;

  // Two-flop synchronisers for pins
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [IPDC_KEYS-1:0] key_s1_ff;
  logic [IPDC_KEYS-1:0] key_s2_ff;

  // Decode of the register port
  // A write that sets both request bits is treated as power-down alone,
  // so the controller never drops into idle after a power-down exit
  wire hit = (bus.addr == IPDC_POWER_CONTROL_ADDR);
  wire wr_hit = bus.wr && hit;
  wire rd_hit = bus.rd && hit;
  wire req_pd = wr_hit && bus.wdata[IPDC_BIT_PDOWN];
  wire req_idle = wr_hit && bus.wdata[IPDC_BIT_IDLE] && !bus.wdata[IPDC_BIT_PDOWN];
  wire any_reset = HW_RESET || POR_EVENT;

  // Synchronised pin levels
  wire ext0_act = pin_s2_ff[0];
  wire ext1_act = pin_s2_ff[1];
  wire bod_act = pin_s2_ff[2] && BOD_ENABLE;
  wire wdt_act = pin_s2_ff[3];
  // Keypad edge opposite to the level seen at entry
  wire key_act = |(key_s2_ff ^ key_entry_ff);

  // Raw wake vector in power-down, gated by enables
  wire [IPDC_NSRC-1:0] pd_raw = {key_act, wdt_act, bod_act, ext1_act, ext0_act};
  wire [IPDC_NSRC-1:0] pd_wake = pd_raw & SRC_ENABLE & {IPDC_NSRC{GLOBAL_INTERRUPT_ENABLE}};
  wire [IPDC_NSRC-1:0] idle_wake = IRQ_PENDING & SRC_ENABLE & {IPDC_NSRC{GLOBAL_INTERRUPT_ENABLE}};

  // Pin synchronisers
  // Every pin is asynchronous to CLOCK, so only the second stage is read
  // by the wake logic; the first stage may be metastable
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      key_s1_ff <= 8'h00;
      key_s2_ff <= 8'h00;
    end else begin
      pin_s1_ff <= {WATCHDOG_IRQ, BROWNOUT_DETECTOR, !EXT1_PIN_N, !EXT0_PIN_N};
      pin_s2_ff <= pin_s1_ff;
      key_s1_ff <= KEY_PIN;
      key_s2_ff <= key_s1_ff;
    end
  end

  // Next state and register update
  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_power_control_reg = power_control_reg_ff;
    if (wr_hit) begin
      nxt_power_control_reg = bus.wdata & IPDC_RW_MASK;
      if (bus.wdata[IPDC_BIT_PDOWN]) begin
        nxt_power_control_reg[IPDC_BIT_IDLE] = 1'b0;
      end
    end
    case (state_ff)
      IPDC_RUN: begin
        if (req_pd) begin
          nxt_state = IPDC_PDOWN;
        end else if (req_idle) begin
          nxt_state = IPDC_IDLE;
        end
      end
      IPDC_IDLE: begin
        if (|idle_wake) begin
          nxt_state = IPDC_WAKE;
          nxt_src = idle_wake;
          nxt_power_control_reg[IPDC_BIT_IDLE] = 1'b0;
        end
      end
      IPDC_PDOWN: begin
        if (|pd_wake) begin
          nxt_state = IPDC_WAKE;
          nxt_src = pd_wake;
          nxt_power_control_reg[IPDC_BIT_PDOWN] = 1'b0;
        end
      end
      IPDC_WAKE: begin
        // Clocks already running; wait for the core to vector
        if (VECTOR_ACK) begin
          nxt_state = IPDC_RUN;
          nxt_src = '0;
        end
      end
      default: nxt_state = IPDC_RUN;
    endcase
    if (any_reset || SW_RESET) begin
      nxt_power_control_reg[IPDC_BIT_IDLE] = 1'b0;
      nxt_power_control_reg[IPDC_BIT_PDOWN] = 1'b0;
      nxt_src = '0;
    end
    if (any_reset) begin
      nxt_state = IPDC_RUN;
    end
    if (POR_EVENT) begin
      nxt_power_control_reg[IPDC_BIT_POF] = 1'b1; // Set wins over clear
    end
  end

  // Output control from the next state
  // Built from the next state so gates and holds change on the same edge
  // as the state itself, with no extra cycle of running clock
  always_comb begin
    nxt_ctl.cpu_clk_en = (nxt_state == IPDC_RUN) || (nxt_state == IPDC_WAKE);
    nxt_ctl.per_clk_en = (nxt_state != IPDC_PDOWN);
    nxt_ctl.pc_hold = (nxt_state == IPDC_IDLE) || (nxt_state == IPDC_PDOWN);
    nxt_ctl.port_hold = nxt_ctl.pc_hold;
    nxt_ctl.flash_stop = (nxt_state == IPDC_PDOWN);
    nxt_ctl.wdt_clear = (nxt_state != state_ff) && (nxt_state != IPDC_RUN);
  end

  // Vector request follows the wake state once the CPU clock is enabled
  assign nxt_wake_irq = (nxt_state == IPDC_WAKE) && nxt_ctl.cpu_clk_en;

  // State registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= IPDC_RUN;
      power_control_reg_ff <= IPDC_POWER_CONTROL_RESET;
      src_ff <= '0;
      // Clocks run and nothing is held while in reset
      ctl_ff <= '{cpu_clk_en: 1'b1, per_clk_en: 1'b1, default: 1'b0};
      wake_irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      power_control_reg_ff <= nxt_power_control_reg;
      src_ff <= nxt_src;
      ctl_ff <= nxt_ctl;
      wake_irq_ff <= nxt_wake_irq;
    end
  end

  // Keypad level capture at entry into power-down
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      key_entry_ff <= 8'h00;
    end else if (state_ff != IPDC_PDOWN) begin
      key_entry_ff <= key_s2_ff;
    end
  end

  // Read data and program restart
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
      restart_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_hit ? power_control_reg_ff : 8'h00;
      restart_ff <= HW_RESET || POR_EVENT;
    end
  end

  assign RDATA = rdata_ff;
  assign CPU_CLK_EN = ctl_ff.cpu_clk_en;
  assign PER_CLK_EN = ctl_ff.per_clk_en;
  assign PC_HOLD = ctl_ff.pc_hold;
  assign PORT_HOLD = ctl_ff.port_hold;
  assign FLASH_STOP = ctl_ff.flash_stop;
  assign WATCHDOG_COUNTER_CLEAR = ctl_ff.wdt_clear;
  assign WAKE_IRQ = wake_irq_ff;
  assign WAKE_SOURCE = src_ff;
  assign PROGRAM_RESTART = restart_ff;
  assign MODE = state_ff;

  // Assertions

  // Gates close on the very edge that takes the power-down request
  pd_clocks_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_RUN && req_pd && !any_reset) |=> (!CPU_CLK_EN && !PER_CLK_EN))
    else $error("power-down did not stop clocks");

  // Idle stops the CPU clock and leaves peripherals running
  idle_clocks_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_RUN && req_idle && !any_reset) |=> (!CPU_CLK_EN && PER_CLK_EN))
    else $error("idle clock gating wrong");

  both_bits_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_RUN && req_pd && !any_reset) |=> (state_ff == IPDC_PDOWN))
    else $error("both bits did not enter power-down");

  // Hardware clears the power-down bit as it wakes
  pd_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_PDOWN && |pd_wake && !any_reset && !wr_hit) |=>
    (!power_control_reg_ff[IPDC_BIT_PDOWN] && state_ff == IPDC_WAKE))
    else $error("power-down bit not cleared on wake");

  // Hardware clears the idle bit as it wakes
  idle_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_IDLE && |idle_wake && !any_reset && !wr_hit) |=>
    !power_control_reg_ff[IPDC_BIT_IDLE])
    else $error("idle bit not cleared on wake");

  // A non-software reset returns to run and asks for a program restart
  reset_exit_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    any_reset |=> (state_ff == IPDC_RUN && PROGRAM_RESTART))
    else $error("reset did not leave low-power mode");

  // With the global enable low no pin may wake power-down
  gate_ignore_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_PDOWN && !GLOBAL_INTERRUPT_ENABLE && !any_reset) |=>
    (state_ff == IPDC_PDOWN))
    else $error("disabled wake accepted");

  // Every move into a low-power or wake state clears the watchdog
  wdt_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff != $past(state_ff) && state_ff != IPDC_RUN) |-> WATCHDOG_COUNTER_CLEAR)
    else $error("watchdog not cleared on entry");

  // Idle holds the program counter and ports with the CPU clock off
  hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_IDLE) |-> (PC_HOLD && PORT_HOLD && !CPU_CLK_EN))
    else $error("hold lost in idle");

  // Power-down stops flash and peripheral clocks
  flash_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_PDOWN) |-> (FLASH_STOP && !PER_CLK_EN))
    else $error("flash not stopped in power-down");

  // The core is never asked to vector on a stopped clock
  wake_clk_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    WAKE_IRQ |-> CPU_CLK_EN)
    else $error("vector before clock runs");

  // With no enabled wake source and no reset, power-down persists
  quiet_pd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_ff == IPDC_PDOWN && pd_wake == '0 && !any_reset) |=> (state_ff == IPDC_PDOWN))
    else $error("power-down left without a wake source");

  // A vector request names the source that woke the core, unless a software reset has cleared that source
  wake_src_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    WAKE_IRQ |-> (WAKE_SOURCE != '0))
    else $error("vector request without a source");

  // Main scenarios
  pd_wake_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
    state_ff == IPDC_PDOWN ##1 state_ff == IPDC_WAKE);
  idle_wake_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
    state_ff == IPDC_IDLE ##1 state_ff == IPDC_WAKE);
  key_wake_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
    state_ff == IPDC_PDOWN && pd_wake[IPDC_SRC_KEY]);
  // Power-down left through a reset
  pd_reset_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
    state_ff == IPDC_PDOWN && any_reset);
  // A pin active while the global enable is low
  masked_pin_c: cover property (@(posedge CLOCK) disable iff (!RST_N)
    state_ff == IPDC_PDOWN && pd_raw != '0 && !GLOBAL_INTERRUPT_ENABLE);

endmodule : ipdc_ctrl

// file: ipdc_core_model.sv
`timescale 1ns/1ps
// Core side: vectors to the waking interrupt once its clock runs
module ipdc_core_model (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WAKE_IRQ,
  input wire logic CPU_CLK_EN,
  input wire logic [3:0] ACK_DELAY,
  output logic VECTOR_ACK
);
  // Cycles spent fetching the vector
  logic [3:0] wait_ff;
  // Set once this wake has been acknowledged
  logic done_ff;
  // One acknowledge per wake, never while the clock is gated
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
      VECTOR_ACK <= 1'b0;
    end else begin
      VECTOR_ACK <= 1'b0;
      if (!WAKE_IRQ) begin
        wait_ff <= 4'h0;
        done_ff <= 1'b0;
      end else if (CPU_CLK_EN && !done_ff) begin
        if (wait_ff == ACK_DELAY) begin
          VECTOR_ACK <= 1'b1;
          done_ff <= 1'b1;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule : ipdc_core_model

// file: test_idle_powerdown_controller.sv
`timescale 1ns/1ps
module test_idle_powerdown_controller
  import ipdc_pkg::*;
;
  logic clk, rst_n, wr, rd, hw, sw, por, gie, e0_n, e1_n, brownout_detector, bod_en, wdt, ack;
  logic [7:0] addr, wdata, rdata, key;
  logic [IPDC_NSRC-1:0] src_en, irq, wsrc;
  logic cpu_en, per_en, pc_h, port_h, fstop, wclr, wirq, rstart;
  logic [1:0] mode;
  logic [3:0] dly;
  // Tallies and watchdog of the run
  int n_fail, checks_done, n_clr, n_rst, cycles;

  ipdc_ctrl uut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .HW_RESET(hw), .SW_RESET(sw), .POR_EVENT(por),
    .GLOBAL_INTERRUPT_ENABLE(gie), .SRC_ENABLE(src_en), .IRQ_PENDING(irq),
    .EXT0_PIN_N(e0_n), .EXT1_PIN_N(e1_n), .BROWNOUT_DETECTOR(brownout_detector), .BOD_ENABLE(bod_en),
    .WATCHDOG_IRQ(wdt), .KEY_PIN(key), .VECTOR_ACK(ack), .CPU_CLK_EN(cpu_en),
    .PER_CLK_EN(per_en), .PC_HOLD(pc_h), .PORT_HOLD(port_h), .FLASH_STOP(fstop),
    .WATCHDOG_COUNTER_CLEAR(wclr), .WAKE_IRQ(wirq), .WAKE_SOURCE(wsrc),
    .PROGRAM_RESTART(rstart), .MODE(mode));

  ipdc_core_model core (.CLOCK(clk), .RST_N(rst_n), .WAKE_IRQ(wirq),
    .CPU_CLK_EN(cpu_en), .ACK_DELAY(dly), .VECTOR_ACK(ack));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts clear and restart pulses, cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (wclr === 1'b1) n_clr++;
    if (rstart === 1'b1) n_rst++;
    if (cycles == 4000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : rd_reg

  // Bounded wait for a mode, then judged
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 30 && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk("mode", {6'h00, m}, {6'h00, mode});
  endtask : wait_mode

  // Drives one wake source active or quiet
  task automatic set_pin(input int s, input logic on);
    @(posedge clk);
    case (s)
      0: e0_n <= !on;
      1: e1_n <= !on;
      2: brownout_detector <= on;
      3: wdt <= on;
      default: key <= on ? 8'h00 : 8'h01;
    endcase
  endtask : set_pin

  task automatic t_regs;
    logic [7:0] q;
    rd_reg(IPDC_POWER_CONTROL_ADDR, q);
    chk("reset value", IPDC_POWER_CONTROL_RESET, q);
    rd_reg(8'h86, q);
    chk("unmapped read", 8'h00, q);
    wr_reg(IPDC_POWER_CONTROL_ADDR, 8'hFC);
    rd_reg(IPDC_POWER_CONTROL_ADDR, q);
    chk("writable bits", 8'hDC, q);
    wr_reg(IPDC_POWER_CONTROL_ADDR, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_idle;
    logic [7:0] q;
    int c0;
    c0 = n_clr;
    wr_reg(IPDC_POWER_CONTROL_ADDR, 8'h01);
    wait_mode(IPDC_IDLE);
    repeat (2) @(posedge clk);
    #1 chk("idle clocks", 8'h01, {6'h00, cpu_en, per_en});
    chk("idle holds", 8'h03, {6'h00, pc_h, port_h});
    chk("idle entry clear", 8'(c0 + 1), 8'(n_clr));
    @(posedge clk) irq <= 5'h01;
    wait_mode(IPDC_RUN);
    @(posedge clk) irq <= 5'h00;
    rd_reg(IPDC_POWER_CONTROL_ADDR, q);
    chk("idle bit", 8'h00, q & 8'h03);
    chk("idle wake clear", 8'(c0 + 2), 8'(n_clr));
    wr_reg(IPDC_POWER_CONTROL_ADDR, 8'h01);
    wait_mode(IPDC_IDLE);
    @(posedge clk) hw <= 1'b1;
    @(posedge clk) hw <= 1'b0;
    wait_mode(IPDC_RUN);
    $display("test idle done");
  endtask : t_idle

  task automatic t_wake(input int s);
    logic [7:0] q;
    int c0;
    dly = 4'(s * 3);
    c0 = n_clr;
    wr_reg(IPDC_POWER_CONTROL_ADDR, s == 4 ? 8'h03 : 8'h02);
    wait_mode(IPDC_PDOWN);
    repeat (2) @(posedge clk);
    #1 chk("pdown clocks", 8'h01, {5'h00, cpu_en, per_en, fstop});
    chk("pdown entry clear", 8'(c0 + 1), 8'(n_clr));
    if (s == 0) begin
      @(posedge clk) gie <= 1'b0;
      set_pin(0, 1'b1);
      repeat (12) @(posedge clk);
      #1 chk("masked wake", 8'h02, {6'h00, mode});
      set_pin(0, 1'b0);
      // Let the synchroniser drain before the enable returns
      repeat (4) @(posedge clk);
      gie <= 1'b1;
      repeat (4) @(posedge clk);
    end
    if (s == 2) begin
      @(posedge clk) bod_en <= 1'b0;
      set_pin(2, 1'b1);
      repeat (12) @(posedge clk);
      #1 chk("brownout disabled", 8'h02, {6'h00, mode});
      @(posedge clk) bod_en <= 1'b1;
    end
    set_pin(s, 1'b1);
    wait_mode(IPDC_WAKE);
    @(posedge clk);
    #1 chk("clock before vector", 8'h03, {6'h00, wirq, cpu_en});
    chk("wake source", 8'(1 << s), {3'h0, wsrc});
    set_pin(s, 1'b0);
    wait_mode(IPDC_RUN);
    rd_reg(IPDC_POWER_CONTROL_ADDR, q);
    chk("request bits", 8'h00, q & 8'h03);
    chk("wake clear", 8'(c0 + 2), 8'(n_clr));
    repeat (6) @(posedge clk);
    $display("test wake source %0d done", s);
  endtask : t_wake

  task automatic t_resets;
    int r0;
    for (int k = 0; k < 2; k++) begin
      wr_reg(IPDC_POWER_CONTROL_ADDR, 8'h02);
      wait_mode(IPDC_PDOWN);
      @(posedge clk) sw <= 1'b1;
      @(posedge clk) sw <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk("software reset", 8'h02, {6'h00, mode});
      r0 = n_rst;
      @(posedge clk) if (k == 0) hw <= 1'b1; else por <= 1'b1;
      @(posedge clk) hw <= 1'b0;
      por <= 1'b0;
      wait_mode(IPDC_RUN);
      repeat (4) @(posedge clk);
      #1 chk("restart pulse", 8'(r0 + 1), 8'(n_rst));
    end
    $display("test resets done");
  endtask : t_resets

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    {rst_n, wr, rd, hw, sw, por, brownout_detector, wdt} = 8'h00;
    {gie, e0_n, e1_n, bod_en} = 4'hF;
    addr = 8'h00;
    wdata = 8'h00;
    key = 8'h01;
    src_en = '1;
    irq = '0;
    dly = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_idle();
    for (int s = 0; s < IPDC_NSRC; s++) t_wake(s);
    t_resets();
    test_done();
  end
endmodule : test_idle_powerdown_controller
